// [logic/dsm_mapper.sv]
// DS3 into STS-1 SPE bit mapper and matching extractor
//
// Notes on behaviour
// - Each row holds exactly 59 fixed stuff bits with no function.
// - Each row carries 621 DS3 data bits, 5589 per envelope.
// - Fixed stuff is sent as zero; the extractor ignores its value.
// - One stuff opportunity per row, nine per envelope, data or junk.
// - Five stuff control bits per row flag the row's opportunity.
// - Control bits all 0 mean opportunity carries data, all 1 mean stuff.
// - Two overhead communication bits per row, exposed on user ports.
// - Data-or-stuff choice follows FIFO fill, i.e. DS3 versus STS-1 timing.
// - 8000 envelopes per second, nominally 5592 DS3 bits each.
// - Nominal envelopes use three opportunities for data, six for stuff.
// - Fast source: four opportunities carry data, 5593 bits in envelope.
// - Extractor outputs exactly the DS3 bits each envelope indicates.
// - Slow source: only two opportunities carry data, 5591 bits.
`timescale 1ns/1ps
`default_nettype none
module dsm_mapper (
   // Clock and reset
   input  wire  logic                 clk_in,
   input  wire  logic                 rstn_in,
   // DS3 source
   input  wire  dsm_pkg::dsm_bit_t    ds3_in,
   output logic                       ds3_rdy_out,
   // Envelope build towards the framer
   input  wire  dsm_pkg::dsm_req_t    map_req_in,
   input  wire  logic [1:0]           ohc_tx_in,
   output dsm_pkg::dsm_ser_t          map_out,
   output logic                       map_slip_out,
   // Envelope from the framer, DS3 recovery
   input  wire  dsm_pkg::dsm_ser_t    dmp_in,
   output dsm_pkg::dsm_bit_t          dmp_ds3_out,
   output dsm_pkg::dsm_ohc_t          ohc_rx_out,
   output logic [12:0]                dmp_cnt_out,
   output logic                       dmp_cnt_vld_out
);
   import dsm_pkg::*;

   // ---------------------------------------------------------------
   // Input buffer
   // ---------------------------------------------------------------
   logic                  fifo_vld;
   logic                  fifo_pop;
   logic [0:0]            fifo_dat;
   logic [4:0]            fifo_lvl;
   logic                  fifo_rdy;

   dsm_fifo #(
      .WIDTH (DSM_FIFO_WIDTH),
      .DEPTH (DSM_FIFO_DEPTH)
   ) u_fifo (
      .clk_in      (clk_in),
      .rstn_in     (rstn_in),
      .in_vld_in   (ds3_in.vld),
      .in_rdy_out  (fifo_rdy),
      .in_dat_in   (ds3_in.dat),
      .out_vld_out (fifo_vld),
      .out_rdy_in  (fifo_pop),
      .out_dat_out (fifo_dat),
      .level_out   (fifo_lvl)
   );

   // Ready comes from the FIFO's own full flop
   assign ds3_rdy_out = fifo_rdy;

   // ---------------------------------------------------------------
   // Mapper position
   // ---------------------------------------------------------------
   dsm_pos_t   map_pos_r;
   dsm_pos_t   map_cur;
   dsm_kind_t  map_kind;
   dsm_adj_t   map_adj_r;
   dsm_adj_t   map_adj_cur;
   logic       map_opp_dat;
   logic [1:0] ohc_tx_r;
   logic       map_need;

   // Start of envelope forces the place back to the first bit
   always_comb begin
      map_cur = map_pos_r;
      if (map_req_in.sof) begin
         map_cur = '0;
      end
   end

   assign map_kind = dsm_kind(map_cur.bit_idx);

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         map_pos_r <= '0;
      end else if (map_req_in.take) begin
         map_pos_r <= dsm_step(map_cur);
      end
   end

   // ---------------------------------------------------------------
   // Justification decision
   // ---------------------------------------------------------------
   // fill level picks envelope adjust
   always_comb begin
      map_adj_cur = map_adj_r;
      if (map_req_in.take && map_cur == '0) begin
         if (fifo_lvl >= DSM_LVL_HI) map_adj_cur = DSM_ADJ_MORE;
         else if (fifo_lvl <= DSM_LVL_LO) map_adj_cur = DSM_ADJ_LESS;
         else map_adj_cur = DSM_ADJ_NONE;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         map_adj_r <= DSM_ADJ_NONE;
      end else begin
         map_adj_r <= map_adj_cur;
      end
   end

   // rows 2, 5 and 8 carry data nominally
   always_comb begin
      map_opp_dat = ((map_cur.row % DSM_ROW_MOD) == DSM_ROW_PHASE);
      case (map_adj_cur)
         DSM_ADJ_MORE: begin
            if (map_cur.row == DSM_ROW_EXTRA) map_opp_dat = 1'b1;
         end
         DSM_ADJ_LESS: begin
            if (map_cur.row == DSM_ROW_DROP) map_opp_dat = 1'b0;
         end
         DSM_ADJ_NONE: begin
            map_opp_dat = map_opp_dat;
         end
         default: begin
            map_opp_dat = map_opp_dat;
         end
      endcase
   end

   // data bits and used opportunities draw from the buffer
   assign map_need = map_req_in.take &&
                     (map_kind == DSM_K_DAT || (map_kind == DSM_K_OPP && map_opp_dat));
   assign fifo_pop = map_need;

   // overhead bits captured once per row
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         ohc_tx_r <= 2'h0;
      end else if (map_req_in.take && map_cur.bit_idx == '0) begin
         ohc_tx_r <= ohc_tx_in;
      end
   end

   // ---------------------------------------------------------------
   // Mapper output
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         map_out      <= '0;
         map_slip_out <= 1'b0;
      end else begin
         map_out.vld  <= map_req_in.take;
         map_out.sof  <= map_req_in.take && map_cur == '0;
         map_slip_out <= map_need && !fifo_vld;
         case (map_kind)
            DSM_K_DAT: begin
               map_out.dat <= fifo_vld & fifo_dat[0];
            end
            DSM_K_OPP: begin
               map_out.dat <= map_opp_dat & fifo_vld & fifo_dat[0];
            end
            // zero for data, one for stuff
            DSM_K_CTL: begin
               map_out.dat <= ~map_opp_dat;
            end
            DSM_K_OHC: begin
               map_out.dat <= (map_cur.bit_idx[2:0] == DSM_C3_OHC0) ? ohc_tx_r[0] : ohc_tx_r[1];
            end
            DSM_K_FIX: begin
               map_out.dat <= 1'b0;
            end
            default: begin
               map_out.dat <= 1'b0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Extractor position
   // ---------------------------------------------------------------
   dsm_pos_t    dmp_pos_r;
   dsm_pos_t    dmp_cur;
   dsm_kind_t   dmp_kind;
   logic [2:0]  dmp_ones_r;
   logic        dmp_opp_dat;
   logic [12:0] dmp_acc_r;
   logic        dmp_take_dat;
   logic        dmp_row_end;
   logic        dmp_spe_end;
   logic [1:0]  ohc_rx_r;

   always_comb begin
      dmp_cur = dmp_pos_r;
      if (dmp_in.sof) begin
         dmp_cur = '0;
      end
   end

   // same layout on the receive side
   assign dmp_kind    = dsm_kind(dmp_cur.bit_idx);
   assign dmp_row_end = dmp_in.vld && dmp_cur.bit_idx == DSM_BIT_LAST;
   assign dmp_spe_end = dmp_row_end && dmp_cur.row == DSM_ROW_LAST;

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         dmp_pos_r <= '0;
      end else if (dmp_in.vld) begin
         dmp_pos_r <= dsm_step(dmp_cur);
      end
   end

   // ---------------------------------------------------------------
   // Stuff control vote
   // ---------------------------------------------------------------
   // count ones among the five control bits
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         dmp_ones_r <= 3'h0;
      end else if (dmp_in.vld) begin
         if (dmp_cur.bit_idx == '0) begin
            dmp_ones_r <= 3'h0;
         end else if (dmp_kind == DSM_K_CTL && dmp_in.dat) begin
            dmp_ones_r <= dmp_ones_r + 3'h1;
         end
      end
   end

   assign dmp_opp_dat = (dmp_ones_r < DSM_VOTE_MIN);

   // fixed stuff and control values never reach the DS3 output
   assign dmp_take_dat = dmp_in.vld &&
                         (dmp_kind == DSM_K_DAT || (dmp_kind == DSM_K_OPP && dmp_opp_dat));

   // ---------------------------------------------------------------
   // Recovered DS3 and per-envelope count
   // ---------------------------------------------------------------
   // emit exactly the indicated data bits
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         dmp_ds3_out <= '0;
      end else begin
         dmp_ds3_out.vld <= dmp_take_dat;
         dmp_ds3_out.dat <= dmp_take_dat & dmp_in.dat;
      end
   end

   // bits per envelope reported at its end
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         dmp_acc_r       <= DSM_CNT_ZERO;
         dmp_cnt_out     <= DSM_CNT_ZERO;
         dmp_cnt_vld_out <= 1'b0;
      end else begin
         dmp_cnt_vld_out <= dmp_spe_end;
         if (dmp_in.vld && dmp_cur == '0) begin
            dmp_acc_r <= dmp_take_dat ? DSM_CNT_ONE : DSM_CNT_ZERO;
         end else if (dmp_take_dat) begin
            dmp_acc_r <= dmp_acc_r + DSM_CNT_ONE;
         end
         if (dmp_spe_end) begin
            dmp_cnt_out <= dmp_acc_r + (dmp_take_dat ? DSM_CNT_ONE : DSM_CNT_ZERO);
         end
      end
   end

   // ---------------------------------------------------------------
   // Overhead communication bits
   // ---------------------------------------------------------------
   // collect the row's two bits
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         ohc_rx_r <= 2'h0;
      end else if (dmp_in.vld && dmp_kind == DSM_K_OHC) begin
         if (dmp_cur.bit_idx[2:0] == DSM_C3_OHC0) ohc_rx_r[0] <= dmp_in.dat;
         else ohc_rx_r[1] <= dmp_in.dat;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         ohc_rx_out <= '0;
      end else begin
         ohc_rx_out.vld <= dmp_row_end;
         if (dmp_row_end) begin
            ohc_rx_out.bits <= ohc_rx_r;
         end
      end
   end
endmodule
`default_nettype wire

// [logic/dsm_pkg.sv]
// Constants, types and helpers shared by the DS3 to STS-1 SPE bit mapper
package dsm_pkg;

   // ---------------------------------------------------------------
   // Envelope geometry (user data area, path overhead column excluded)
   // ---------------------------------------------------------------
   localparam logic [3:0]  DSM_ROW_LAST    = 4'h8;
   localparam logic [9:0]  DSM_BIT_LAST    = 10'h2AF;
   localparam logic [12:0] DSM_CNT_ZERO    = 13'h0000;
   localparam logic [12:0] DSM_CNT_ONE     = 13'h0001;
   localparam int unsigned DSM_FIX_PER_ROW = 59;
   localparam int unsigned DSM_DAT_PER_ROW = 621;
   localparam int unsigned DSM_CTL_PER_ROW = 5;

   // Byte slots within a row holding the all-fixed bytes (R0 to R5) and the mixed bytes (C1 to C3)
   localparam logic [6:0]  DSM_BYTE_C1     = 7'h02;
   localparam logic [6:0]  DSM_BYTE_C2     = 7'h1F;
   localparam logic [6:0]  DSM_BYTE_C3     = 7'h3C;
   localparam logic [6:0]  DSM_BYTE_R0     = 7'h00;
   localparam logic [6:0]  DSM_BYTE_R1     = 7'h01;
   localparam logic [6:0]  DSM_BYTE_R2     = 7'h1D;
   localparam logic [6:0]  DSM_BYTE_R3     = 7'h1E;
   localparam logic [6:0]  DSM_BYTE_R4     = 7'h3A;
   localparam logic [6:0]  DSM_BYTE_R5     = 7'h3B;

   // Bit slots inside the mixed bytes, first transmitted bit is 0
   localparam logic [2:0]  DSM_C1_CTL      = 3'h2;
   localparam logic [2:0]  DSM_C1_DAT      = 3'h3;
   localparam logic [2:0]  DSM_CX_CTL_END  = 3'h2;
   localparam logic [2:0]  DSM_C3_OHC0     = 3'h4;
   localparam logic [2:0]  DSM_C3_OHC1     = 3'h5;
   localparam logic [2:0]  DSM_C3_OPP      = 3'h7;

   // ---------------------------------------------------------------
   // Justification
   // ---------------------------------------------------------------
   localparam logic [3:0]  DSM_ROW_MOD     = 4'h3;
   localparam logic [3:0]  DSM_ROW_PHASE   = 4'h2;
   localparam logic [3:0]  DSM_ROW_EXTRA   = 4'h0;
   localparam logic [3:0]  DSM_ROW_DROP    = 4'h8;
   localparam int unsigned DSM_FIFO_DEPTH  = 16;
   localparam int unsigned DSM_FIFO_WIDTH  = 1;
   localparam logic [4:0]  DSM_LVL_HI      = 5'h0C;
   localparam logic [4:0]  DSM_LVL_LO      = 5'h04;
   localparam logic [2:0]  DSM_VOTE_MIN    = 3'h3;

   typedef enum {DSM_K_FIX, DSM_K_DAT, DSM_K_CTL, DSM_K_OPP, DSM_K_OHC} dsm_kind_t;
   typedef enum {DSM_ADJ_NONE, DSM_ADJ_MORE, DSM_ADJ_LESS} dsm_adj_t;

   typedef struct packed {logic [3:0] row; logic [9:0] bit_idx;} dsm_pos_t;
   typedef struct packed {logic vld; logic dat;} dsm_bit_t;
   typedef struct packed {logic sof; logic take;} dsm_req_t;
   typedef struct packed {logic sof; logic vld; logic dat;} dsm_ser_t;
   typedef struct packed {logic vld; logic [1:0] bits;} dsm_ohc_t;

   // Kind of a bit from its place in the row
   function automatic dsm_kind_t dsm_kind(input logic [9:0] b);
      logic [6:0] by;
      logic [2:0] k;
      dsm_kind_t  r;
      by = b[9:3];
      k  = b[2:0];
      r  = DSM_K_DAT;
      if (by == DSM_BYTE_R0 || by == DSM_BYTE_R1 || by == DSM_BYTE_R2 ||
          by == DSM_BYTE_R3 || by == DSM_BYTE_R4 || by == DSM_BYTE_R5) begin
         r = DSM_K_FIX;
      end else if (by == DSM_BYTE_C1) begin
         r = (k == DSM_C1_CTL) ? DSM_K_CTL : ((k >= DSM_C1_DAT) ? DSM_K_DAT : DSM_K_FIX);
      end else if (by == DSM_BYTE_C2) begin
         r = (k < DSM_CX_CTL_END) ? DSM_K_CTL : DSM_K_FIX;
      end else if (by == DSM_BYTE_C3) begin
         if (k < DSM_CX_CTL_END) r = DSM_K_CTL;
         else if (k == DSM_C3_OHC0 || k == DSM_C3_OHC1) r = DSM_K_OHC;
         else if (k == DSM_C3_OPP) r = DSM_K_OPP;
         else r = DSM_K_FIX;
      end
      return r;
   endfunction

   // Next place in the envelope
   function automatic dsm_pos_t dsm_step(input dsm_pos_t p);
      dsm_pos_t n;
      n = p;
      if (p.bit_idx == DSM_BIT_LAST) begin
         n.bit_idx = '0;
         n.row     = (p.row == DSM_ROW_LAST) ? 4'h0 : p.row + 4'h1;
      end else begin
         n.bit_idx = p.bit_idx + 10'h001;
      end
      return n;
   endfunction

endpackage

// [logic/dsm_fifo.sv]
// Flip-flop FIFO with valid/ready on both sides and a fill level
`timescale 1ns/1ps
`default_nettype none
module dsm_fifo #(
   parameter int unsigned WIDTH = 1,
   parameter int unsigned DEPTH = 16
) (
   // Clock and reset
   input  wire  logic                       clk_in,
   input  wire  logic                       rstn_in,
   // Fill side
   input  wire  logic                       in_vld_in,
   output logic                             in_rdy_out,
   input  wire  logic [WIDTH-1:0]           in_dat_in,
   // Drain side
   output logic                             out_vld_out,
   input  wire  logic                       out_rdy_in,
   output logic [WIDTH-1:0]                 out_dat_out,
   output logic [$clog2(DEPTH):0]           level_out
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wp_r;
   logic [AW-1:0]    rp_r;
   logic [AW:0]      cnt_r;
   logic             nfull_r;
   logic             push;
   logic             pop;
   logic [AW:0]      cnt_nxt;

   assign push        = in_vld_in & nfull_r;
   assign pop         = out_rdy_in & (cnt_r != '0);
   assign cnt_nxt     = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   assign in_rdy_out  = nfull_r;
   assign out_vld_out = (cnt_r != '0);
   assign out_dat_out = mem_r[rp_r];
   assign level_out   = cnt_r;

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_r[wp_r] <= in_dat_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         wp_r    <= '0;
         rp_r    <= '0;
         cnt_r   <= '0;
         nfull_r <= 1'b1;
      end else begin
         if (push) wp_r <= wp_r + 1'b1;
         if (pop) rp_r <= rp_r + 1'b1;
         cnt_r   <= cnt_nxt;
         nfull_r <= (cnt_nxt != DEPTH[AW:0]);
      end
   end
endmodule
`default_nettype wire

// [test/dsm_mapper_properties.sv]
// Port-level checker for the DS3 envelope bit mapper
`timescale 1ns/1ps
`default_nettype none
module dsm_mapper_properties (
   // Watched ports
   input  wire logic              clk_in,
   input  wire logic              rstn_in,
   input  wire dsm_pkg::dsm_bit_t ds3_in,
   input  wire logic              ds3_rdy_out,
   input  wire dsm_pkg::dsm_req_t map_req_in,
   input  wire logic [1:0]        ohc_tx_in,
   input  wire dsm_pkg::dsm_ser_t map_out,
   input  wire logic              map_slip_out,
   input  wire dsm_pkg::dsm_ser_t dmp_in,
   input  wire dsm_pkg::dsm_bit_t dmp_ds3_out,
   input  wire dsm_pkg::dsm_ohc_t ohc_rx_out,
   input  wire logic [12:0]       dmp_cnt_out,
   input  wire logic              dmp_cnt_vld_out
);
   import dsm_pkg::*;
   // ---------------------------------------------
   // Recovered bits since the last envelope end
   // ---------------------------------------------
   logic [12:0] seen_r;
   always_ff @(posedge clk_in) begin
      if (!rstn_in || (dmp_in.vld && dmp_in.sof) || dmp_cnt_vld_out) begin
         seen_r <= 13'h0000;
      end else if (dmp_ds3_out.vld) begin
         seen_r <= seen_r + 13'h0001;
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   a_take_answer: assert property (map_req_in.take |=> map_out.vld)
      else $error("map bit missing after take");
   a_no_spurious: assert property (!map_req_in.take |=> !map_out.vld)
      else $error("map bit without take");
   a_sof_follows: assert property (map_req_in.take && map_req_in.sof |=> map_out.sof && map_out.vld)
      else $error("envelope start not marked");
   a_slip_zero: assert property (map_slip_out |-> map_out.vld && !map_out.dat)
      else $error("underrun bit not zero");
   a_ds3_cause: assert property (dmp_ds3_out.vld |-> $past(dmp_in.vld))
      else $error("recovered bit without input bit");
   a_env_count: assert property (dmp_cnt_vld_out |-> dmp_cnt_out == seen_r + 13'(dmp_ds3_out.vld))
      else $error("envelope count differs from bits output");
   a_cnt_hold: assert property (!dmp_cnt_vld_out |-> $stable(dmp_cnt_out))
      else $error("count changed without pulse");
   a_cnt_apart: assert property (dmp_cnt_vld_out |=> !dmp_cnt_vld_out [*8])
      else $error("envelope ends too close");
   a_ohc_cause: assert property (ohc_rx_out.vld |-> $past(dmp_in.vld))
      else $error("row end without input bit");
   a_rdy_fall: assert property ($fell(ds3_rdy_out) |-> $past(ds3_in.vld) || $past(ds3_in.vld, 2))
      else $error("buffer full without push");
   a_reset_quiet: assert property (disable iff (1'b0) !rstn_in |=> !map_out.vld && !dmp_ds3_out.vld)
      else $error("output active in reset");
endmodule
`default_nettype wire

// [test/dsm_framer_model.sv]
// Behavioural framer: requests envelope bits and loops them back
`timescale 1ns/1ps
`default_nettype none
module dsm_framer_model (
   // Clock, reset and bench control
   input  wire logic              clk_in,
   input  wire logic              rstn_in,
   input  wire logic              go_in,
   input  wire logic              gap_in,
   input  wire logic              err_in,
   // Mapper side
   output dsm_pkg::dsm_req_t      req_out,
   input  wire dsm_pkg::dsm_ser_t map_in,
   output dsm_pkg::dsm_ser_t      dmp_out,
   // Envelope summary
   output logic                   busy_out,
   output logic [3:0]             opp_dat_out,
   output logic [3:0]             ctl_bad_out
);
   import dsm_pkg::*;
   logic [12:0] left_r, idx_r, cur;
   logic [9:0]  b;
   logic [6:0]  by;
   logic [2:0]  ones_r;
   logic        pace_r, tog_r, is_ctl, is_fix;
   assign busy_out = (left_r != 13'h0000);
   always_comb begin
      cur = map_in.sof ? 13'h0000 : idx_r;
      b = 10'(cur % 13'd688);
      by = b[9:3];
      is_ctl = (by == DSM_BYTE_C1 && b[2:0] == DSM_C1_CTL) ||
               ((by == DSM_BYTE_C2 || by == DSM_BYTE_C3) && b[2:0] < DSM_CX_CTL_END);
      is_fix = by inside {DSM_BYTE_R0, DSM_BYTE_R1, DSM_BYTE_R2, DSM_BYTE_R3, DSM_BYTE_R4, DSM_BYTE_R5};
      dmp_out.sof = map_in.sof;
      dmp_out.vld = map_in.vld;
      // corrupt fixed bits and one control bit
      dmp_out.dat = map_in.vld ? map_in.dat ^ (err_in && (is_fix || (is_ctl && by == DSM_BYTE_C2
                    && b[2:0] == 3'h0))) : tog_r;
   end
   // control bits of a row agree
   always_ff @(posedge clk_in) begin
      tog_r <= rstn_in ? ~tog_r : 1'b0;
      if (!rstn_in || (map_in.vld && map_in.sof)) begin
         idx_r <= map_in.vld ? 13'h0001 : 13'h0000;
         ones_r <= 3'h0;
         opp_dat_out <= 4'h0;
         ctl_bad_out <= 4'h0;
      end else if (map_in.vld) begin
         idx_r <= cur + 13'h0001;
         ones_r <= (b == 10'h2AF) ? 3'h0 : ones_r + 3'(is_ctl && map_in.dat);
         if (b == 10'h2AF && ones_r == 3'h0) opp_dat_out <= opp_dat_out + 4'h1;
         if (b == 10'h2AF && ones_r != 3'h0 && ones_r != 3'h5) ctl_bad_out <= ctl_bad_out + 4'h1;
      end
   end
   // Envelope requests, one per cycle or every other cycle
   always_ff @(posedge clk_in) begin
      req_out <= '0;
      // Pacing must start from a known phase or gapped requests never issue
      pace_r <= rstn_in ? ~pace_r : 1'b0;
      if (!rstn_in) begin
         left_r <= 13'h0000;
      end else if (left_r == 13'h0000) begin
         left_r <= go_in ? 13'h1830 : 13'h0000;
      end else if (!gap_in || pace_r) begin
         req_out.take <= 1'b1;
         req_out.sof <= (left_r == 13'h1830);
         left_r <= left_r - 13'h0001;
      end
   end
endmodule
`default_nettype wire

// [test/tb_dsm_mapper.sv]
// Self-checking bench for the DS3 envelope bit mapper
`timescale 1ns/1ps
`default_nettype none
module tb_dsm_mapper;
   import dsm_pkg::*;
   logic        clk, rstn, ds3_rdy, slip, env_cnt_vld, go, gap, err, busy, chk_data;
   dsm_bit_t    ds3, ds3_rx;
   dsm_req_t    req;
   dsm_ser_t    map_bits, dmp_bits;
   dsm_ohc_t    ohc_rx;
   logic [1:0]  ohc_tx;
   logic [12:0] env_cnt;
   logic [3:0]  opp_dat, ctl_bad;
   int          failures, checks_done, bits_left, seq, slips, ohc_seen;
   logic        exp_q[$];
   initial clk = 1'b0;
   always #5 clk = ~clk;
   dsm_mapper dut (.clk_in(clk), .rstn_in(rstn), .ds3_in(ds3), .ds3_rdy_out(ds3_rdy), .map_req_in(req),
      .ohc_tx_in(ohc_tx), .map_out(map_bits), .map_slip_out(slip), .dmp_in(dmp_bits), .dmp_ds3_out(ds3_rx),
      .ohc_rx_out(ohc_rx), .dmp_cnt_out(env_cnt), .dmp_cnt_vld_out(env_cnt_vld));
   dsm_framer_model u_framer (.clk_in(clk), .rstn_in(rstn), .go_in(go), .gap_in(gap), .err_in(err),
      .req_out(req), .map_in(map_bits), .dmp_out(dmp_bits), .busy_out(busy), .opp_dat_out(opp_dat),
      .ctl_bad_out(ctl_bad));
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done = checks_done + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic test_done();
      if (failures == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // DS3 source: holds each bit until taken
   always @(posedge clk) begin
      if (ds3.vld === 1'b1 && ds3_rdy === 1'b1) begin
         exp_q.push_back(ds3.dat);
         seq = seq + 1;
         bits_left = bits_left - 1;
      end
      #1;
      ds3.dat = (bits_left != 0) ? (seq[0] ^ seq[2]) : ~ds3.dat;
      ds3.vld = (bits_left != 0);
   end
   // Recovered stream and overhead monitor
   always @(posedge clk) begin
      if (slip === 1'b1) slips = slips + 1;
      if (ohc_rx.vld === 1'b1) ohc_seen = ohc_seen + 1;
      if (ohc_rx.vld === 1'b1) check("ohc bits", 16'(ohc_rx.bits), 16'(ohc_tx));
      if (ds3_rx.vld === 1'b1 && chk_data) check("ds3 bit", 16'(ds3_rx.dat), 16'(exp_q.pop_front()));
   end
   task automatic run_env(input logic g, input logic e, input logic [1:0] ohc);
      int n;
      @(posedge clk);
      #1;
      gap = g;
      err = e;
      ohc_tx = ohc;
      slips = 0;
      ohc_seen = 0;
      go = 1'b1;
      @(posedge clk);
      #1;
      go = 1'b0;
      for (n = 0; env_cnt_vld !== 1'b1; n++) begin
         if (n > 20000) begin
            failures = failures + 1;
            test_done();
         end
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      #1;
   endtask
   task automatic scen_slow();
      bits_left = 0;
      run_env(1'b0, 1'b0, 2'h1);
      check("slow count", 16'(env_cnt), 16'd5591);
      check("slow data opps", 16'(opp_dat), 16'd2);
      check("slow slips", 16'(slips), 16'd5591);
      check("rows of ohc", 16'(ohc_seen), 16'd9);
      check("control agree", 16'(ctl_bad), 16'd0);
   endtask
   task automatic scen_nominal();
      int n;
      exp_q.delete();
      bits_left = 8;
      repeat (12) @(posedge clk);
      chk_data = 1'b1;
      fork
         run_env(1'b1, 1'b0, 2'h2);
         begin
            for (n = 0; n < 20 && map_bits.vld !== 1'b1; n++) @(posedge clk);
            if (n >= 20) begin
               failures = failures + 1;
               test_done();
            end
            bits_left = 1000000;
         end
      join
      check("nominal count", 16'(env_cnt), 16'd5592);
      check("nominal data opps", 16'(opp_dat), 16'd3);
      check("nominal slips", 16'(slips), 16'd0);
   endtask
   task automatic scen_fast();
      run_env(1'b0, 1'b0, 2'h3);
      check("fast count", 16'(env_cnt), 16'd5593);
      check("fast data opps", 16'(opp_dat), 16'd4);
      check("fast slips", 16'(slips), 16'd0);
   endtask
   task automatic scen_votes();
      run_env(1'b0, 1'b1, 2'h2);
      check("voted count", 16'(env_cnt), 16'd5593);
      check("rows of ohc", 16'(ohc_seen), 16'd9);
   endtask
   initial begin
      rstn = 1'b0;
      ds3 = '0;
      ohc_tx = 2'h0;
      {go, gap, err, chk_data} = 4'h0;
      {failures, checks_done, bits_left, seq, slips, ohc_seen} = '0;
      repeat (8) @(posedge clk);
      #1;
      rstn = 1'b1;
      scen_slow();
      scen_nominal();
      scen_fast();
      scen_votes();
      test_done();
   end
endmodule
bind dsm_mapper dsm_mapper_properties u_props (.clk_in(clk_in), .rstn_in(rstn_in), .ds3_in(ds3_in),
   .ds3_rdy_out(ds3_rdy_out), .map_req_in(map_req_in), .ohc_tx_in(ohc_tx_in), .map_out(map_out),
   .map_slip_out(map_slip_out), .dmp_in(dmp_in), .dmp_ds3_out(dmp_ds3_out), .ohc_rx_out(ohc_rx_out),
   .dmp_cnt_out(dmp_cnt_out), .dmp_cnt_vld_out(dmp_cnt_vld_out));
`default_nettype wire
